// ===== rtl/aof_pkg.sv
// shared constants, encodings and carrier types of the sample output formatter
package aof_pkg;
  // register offsets on the configuration port
  localparam logic [6:0] ADDR_RESET = 7'h00;
  localparam logic [6:0] ADDR_POWER = 7'h01;
  localparam logic [6:0] ADDR_TIMING = 7'h02;
  localparam logic [6:0] ADDR_OUTPUT_MODE_FIELD = 7'h03;
  localparam logic [6:0] ADDR_FORMAT = 7'h04;
  localparam logic [6:0] ADDR_STATUS = 7'h05;
  // field positions
  localparam int RESET_BIT = 7;
  localparam int PWR_LSB = 0;
  localparam int DCS_BIT = 0;
  localparam int CPH_LSB = 1;
  localparam int CINV_BIT = 3;
  localparam int MODE_LSB = 0;
  localparam int HIZ_BIT = 2;
  localparam int TERM_BIT = 3;
  localparam int ILVDS_LSB = 4;
  localparam int SGN_BIT = 0;
  localparam int SCR_BIT = 1;
  localparam int APM_BIT = 2;
  localparam int PAT_LSB = 3;
  localparam int STAT_READY_BIT = 0;
  localparam int STAT_PAR_BIT = 1;
  localparam int STAT_DOWN_BIT = 2;
  // reset value of every mode register
  localparam logic [7:0] REG_RESET_VAL = 8'h00;
  // encodings
  localparam logic [1:0] PWR_NORMAL = 2'h0;
  localparam logic [1:0] PWR_NAP = 2'h1;
  localparam logic [1:0] PWR_SLEEP = 2'h3;
  localparam logic [1:0] MODE_CMOS = 2'h0;
  localparam logic [1:0] MODE_DDR_LVDS = 2'h1;
  localparam logic [1:0] MODE_DDR_CMOS = 2'h2;
  localparam logic [2:0] PAT_ZEROS = 3'h1;
  localparam logic [2:0] PAT_ONES = 3'h3;
  localparam logic [2:0] PAT_CHECKER = 3'h5;
  localparam logic [2:0] PAT_ALTERNATE = 3'h7;
  localparam logic [2:0] ILVDS_3P5MA = 3'h0;
  // pattern and code values, overrange flag on top
  localparam logic [14:0] WORD_ONES = 15'h7FFF;
  localparam logic [14:0] WORD_ZEROS = 15'h0000;
  localparam logic [14:0] WORD_CHECK_A = 15'h5555;
  localparam logic [14:0] WORD_CHECK_B = 15'h2AAA;
  localparam logic [13:0] ODD_BITS = 14'h2AAA;
  localparam logic [15:0] CODE_MAX = 16'h1FFF;
  localparam logic [15:0] CODE_MIN = 16'hE000;
  // timing
  localparam int CLK_HZ = 25_000_000;
  localparam int SLEEP_WAKE_US = 2000;
  localparam int NAP_SETTLE_US = 50;
  localparam int NAP_WAKE_SAMPLES = 100;
  localparam int SLEEP_WAKE_CYCLES = SLEEP_WAKE_US * (CLK_HZ / 1_000_000);
  localparam int NAP_SETTLE_CYCLES = NAP_SETTLE_US * (CLK_HZ / 1_000_000);

  typedef enum logic [1:0] {
    AOF_RUN = 2'b00,
    AOF_DOWN = 2'b01,
    AOF_WAKE = 2'b10
  } aof_pwr_t;

  typedef struct packed {
    logic clock_invert;
    logic [1:0] clock_delay_field;
    logic duty_cycle_stabilizer;
    logic [2:0] lvds_current;
    logic term_en;
    logic output_hiz;
    logic [1:0] output_mode_field;
    logic [2:0] pattern_select;
    logic alternate_polarity_mode;
    logic output_scrambler_enable;
    logic signed_format_select;
    logic [1:0] power_state_field;
  } aof_cfg_t;

  typedef struct packed {
    logic ovr;
    logic [13:0] bits;
  } aof_word_t;
endpackage

// ===== rtl/aof_formatter.sv
// sample output formatter: coding, scrambling, test patterns, ddr mux, forwarded clock, power states
// What this block does
// - overrange flag high when input out of range, same latency as data
// - full-rate cmos: data changes on true clock falling edge, receiver uses rising
// - ddr modes: data changes on both clock edges, two bits per line
// - forwarded clock delay of 0, 45, 90 or 135 degrees
// - separate clock invert control, independent of delay
// - offset binary by default, two's complement when format bit set
// - midscale codes, signed form is msb inverted, clamp over-range with flag
// - scrambler xors lsb into other data bits, lsb flag clock untouched
// - alternate polarity inverts odd data bits only
// - scrambler and alternate polarity enable independently
// - alternate polarity forces offset binary
// - four test patterns: ones, zeros, alternating, checkerboard
// - test patterns override all other formatting
// - output disable puts all outputs incl flag and clock high impedance
// - sleep powers everything down, data valid 2 ms after wake
// - nap keeps references, data valid after 100 samples plus 50 us
// - nap only from the power register, never from straps
// - mode pin high makes serial pins static configuration straps
// - strap clock pin: 0 full-rate cmos, 1 ddr lvds 3.5 ma no termination
// - strap select pin drives stabilizer, strap input pin selects sleep
// - power field: 00 normal, 01 nap, 11 sleep, 10 unused
// - mode field: 00 cmos, 01 ddr lvds, 10 ddr cmos, 11 unused
// - delay field: 00 none, 01 eighth, 10 quarter, 11 three eighths
//
// The address map and the plain strobed port were decided locally.
`timescale 1ns/1ps
module aof_formatter #(
  parameter int SLEEP_WAKE = aof_pkg::SLEEP_WAKE_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register port
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // encode clock and converter core sample, both asynchronous
  input wire logic enc_clk_pin,
  input wire logic [15:0] core_sample_pin,
  // strap pins
  input wire logic programming_mode_select,
  input wire logic select_strap_pin,
  input wire logic clock_strap_pin,
  input wire logic input_strap_pin,
  // sample outputs with enables
  output logic [13:0] sample_bits,
  output logic [13:0] sample_bits_oe,
  output logic overrange_flag,
  output logic overrange_flag_oe,
  output logic forwarded_sample_clock,
  output logic forwarded_sample_clock_oe,
  // driver and analog control levels
  output logic lvds_select,
  output logic [2:0] lvds_current,
  output logic lvds_term_en,
  output logic duty_cycle_stabilizer,
  output logic core_nap,
  output logic core_sleep,
  output logic output_ready
);

  // offset binary then signed, clamp and flag out-of-range codes
  function automatic aof_pkg::aof_word_t fmt_sample(input aof_pkg::aof_cfg_t c, input logic [15:0] s,
                                                    input logic phase);
    aof_pkg::aof_word_t w;
    logic [13:0] code;
    logic over;
    logic under;
    w = '0;
    over = !s[15] && (s > aof_pkg::CODE_MAX);
    under = s[15] && (s < aof_pkg::CODE_MIN);
    code = over ? aof_pkg::CODE_MAX[13:0] : (under ? aof_pkg::CODE_MIN[13:0] : s[13:0]);
    w.ovr = over | under;
    w.bits = {~code[13], code[12:0]};                           // offset binary
    if (c.signed_format_select && !c.alternate_polarity_mode)
      w.bits[13] = ~w.bits[13];
    if (c.output_scrambler_enable)
      w.bits[13:1] = w.bits[13:1] ^ {13{w.bits[0]}};
    if (c.alternate_polarity_mode)
      w.bits = w.bits ^ aof_pkg::ODD_BITS;
    case (c.pattern_select)                                     // test patterns win
      aof_pkg::PAT_ZEROS: w = aof_pkg::WORD_ZEROS;
      aof_pkg::PAT_ONES: w = aof_pkg::WORD_ONES;
      aof_pkg::PAT_CHECKER: w = phase ? aof_pkg::WORD_CHECK_B : aof_pkg::WORD_CHECK_A;
      aof_pkg::PAT_ALTERNATE: w = phase ? aof_pkg::WORD_ONES : aof_pkg::WORD_ZEROS;
      default: w = w;
    endcase
    return w;
  endfunction

  // ddr mode test, used by the mux and by the enables
  function automatic logic is_ddr(input logic [1:0] m);
    return (m == aof_pkg::MODE_DDR_LVDS) || (m == aof_pkg::MODE_DDR_CMOS);
  endfunction

  // two-flop synchronisers for every asynchronous input
  logic [1:0] enc_s_r;
  logic [15:0] smp_s1_r;
  logic [15:0] smp_s2_r;
  logic [3:0] strap_s1_r;
  logic [3:0] strap_s2_r;
  logic enc_d_r;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      enc_s_r <= 2'h0;
      smp_s1_r <= 16'h0000;
      smp_s2_r <= 16'h0000;
      strap_s1_r <= 4'h0;
      strap_s2_r <= 4'h0;
      enc_d_r <= 1'b0;
    end else begin
      enc_s_r <= {enc_s_r[0], enc_clk_pin};
      smp_s1_r <= core_sample_pin;
      smp_s2_r <= smp_s1_r;
      strap_s1_r <= {programming_mode_select, select_strap_pin, clock_strap_pin, input_strap_pin};
      strap_s2_r <= strap_s1_r;
      enc_d_r <= enc_s_r[1];
    end
  end

  wire boundary = enc_s_r[1] & ~enc_d_r;
  wire par_mode = strap_s2_r[3];

  // mode registers, software-reset by a write of bit 7 to the reset register
  aof_pkg::aof_cfg_t cfg_r;
  wire [23:0] cfg_rst_bits = {3{aof_pkg::REG_RESET_VAL}};
  wire soft_reset = reg_wr && (reg_addr == aof_pkg::ADDR_RESET) && reg_wdata[aof_pkg::RESET_BIT];
  wire wr_power = reg_wr && (reg_addr == aof_pkg::ADDR_POWER);
  wire wr_timing = reg_wr && (reg_addr == aof_pkg::ADDR_TIMING);
  wire wr_output_mode_field = reg_wr && (reg_addr == aof_pkg::ADDR_OUTPUT_MODE_FIELD);
  wire wr_format = reg_wr && (reg_addr == aof_pkg::ADDR_FORMAT);
  always_ff @(posedge ref_clk) begin
    if (rst || soft_reset) begin
      cfg_r <= aof_pkg::aof_cfg_t'(cfg_rst_bits[$bits(aof_pkg::aof_cfg_t) - 1:0]);
    end else begin
      if (wr_power)
        cfg_r.power_state_field <= reg_wdata[aof_pkg::PWR_LSB +: 2];
      if (wr_timing) begin
        cfg_r.clock_invert <= reg_wdata[aof_pkg::CINV_BIT];
        cfg_r.clock_delay_field <= reg_wdata[aof_pkg::CPH_LSB +: 2];
        cfg_r.duty_cycle_stabilizer <= reg_wdata[aof_pkg::DCS_BIT];
      end
      if (wr_output_mode_field) begin
        cfg_r.lvds_current <= reg_wdata[aof_pkg::ILVDS_LSB +: 3];
        cfg_r.term_en <= reg_wdata[aof_pkg::TERM_BIT];
        cfg_r.output_hiz <= reg_wdata[aof_pkg::HIZ_BIT];
        cfg_r.output_mode_field <= reg_wdata[aof_pkg::MODE_LSB +: 2];
      end
      if (wr_format) begin
        cfg_r.pattern_select <= reg_wdata[aof_pkg::PAT_LSB +: 3];
        cfg_r.alternate_polarity_mode <= reg_wdata[aof_pkg::APM_BIT];
        cfg_r.output_scrambler_enable <= reg_wdata[aof_pkg::SCR_BIT];
        cfg_r.signed_format_select <= reg_wdata[aof_pkg::SGN_BIT];
      end
    end
  end

  // straps replace the registers in parallel mode; nap has no strap encoding
  aof_pkg::aof_cfg_t strap_cfg;
  aof_pkg::aof_cfg_t live_cfg;
  always_comb begin
    strap_cfg = '0;
    strap_cfg.duty_cycle_stabilizer = strap_s2_r[2];
    strap_cfg.output_mode_field = strap_s2_r[1] ? aof_pkg::MODE_DDR_LVDS : aof_pkg::MODE_CMOS;
    strap_cfg.lvds_current = aof_pkg::ILVDS_3P5MA;
    strap_cfg.power_state_field = strap_s2_r[0] ? aof_pkg::PWR_SLEEP : aof_pkg::PWR_NORMAL;
    live_cfg = par_mode ? strap_cfg : cfg_r;
  end

  // power field decode; 10 is unused and treated as normal
  wire want_nap = live_cfg.power_state_field == aof_pkg::PWR_NAP;
  wire want_sleep = live_cfg.power_state_field == aof_pkg::PWR_SLEEP;

  // power state machine with wake-up settling counts
  aof_pkg::aof_pwr_t pwr_r;
  aof_pkg::aof_pwr_t pwr_nxt;
  logic from_sleep_r;
  logic [15:0] wake_cnt_r;
  logic [6:0] wake_smp_r;
  wire smp_done = wake_smp_r >= 7'(aof_pkg::NAP_WAKE_SAMPLES);
  wire wake_done = from_sleep_r ? (wake_cnt_r >= 16'(SLEEP_WAKE - 1)) :
                   (smp_done && (wake_cnt_r >= 16'(aof_pkg::NAP_SETTLE_CYCLES - 1)));
  always_comb begin
    case (pwr_r)
      aof_pkg::AOF_RUN: pwr_nxt = (want_nap || want_sleep) ? aof_pkg::AOF_DOWN : aof_pkg::AOF_RUN;
      aof_pkg::AOF_DOWN: pwr_nxt = (want_nap || want_sleep) ? aof_pkg::AOF_DOWN : aof_pkg::AOF_WAKE;
      aof_pkg::AOF_WAKE: pwr_nxt = (want_nap || want_sleep) ? aof_pkg::AOF_DOWN :
                                   (wake_done ? aof_pkg::AOF_RUN : aof_pkg::AOF_WAKE);
      default: pwr_nxt = aof_pkg::AOF_RUN;
    endcase
  end

  // nap waits the sample count before its settle time starts; sleep counts cycles only
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pwr_r <= aof_pkg::AOF_RUN;
      from_sleep_r <= 1'b0;
      wake_cnt_r <= 16'h0000;
      wake_smp_r <= 7'h00;
    end else begin
      pwr_r <= pwr_nxt;
      if (pwr_r == aof_pkg::AOF_DOWN) begin
        wake_cnt_r <= 16'h0000;
        wake_smp_r <= 7'h00;
        if (want_sleep)
          from_sleep_r <= 1'b1;
        else if (want_nap)
          from_sleep_r <= 1'b0;
      end else if (pwr_r == aof_pkg::AOF_WAKE) begin
        if (boundary && !smp_done)
          wake_smp_r <= wake_smp_r + 7'h01;
        if (from_sleep_r || smp_done)
          wake_cnt_r <= wake_cnt_r + 16'h0001;
      end
    end
  end

  wire running = pwr_r != aof_pkg::AOF_DOWN;

  // encode period measurement in reference cycles, saturating
  logic [7:0] cyc_r;
  logic [7:0] period_r;
  wire [7:0] cyc_nxt = boundary ? 8'h00 : ((cyc_r == 8'hFF) ? cyc_r : cyc_r + 8'h01);
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cyc_r <= 8'h00;
      period_r <= 8'h00;
    end else begin
      cyc_r <= cyc_nxt;
      if (boundary)
        period_r <= (cyc_r == 8'hFF) ? cyc_r : cyc_r + 8'h01;
    end
  end

  // settings frozen per sample so no word mixes old and new
  aof_pkg::aof_cfg_t word_cfg_r;
  aof_pkg::aof_word_t word_r;
  logic pat_phase_r;
  wire aof_pkg::aof_word_t word_nxt = fmt_sample(live_cfg, smp_s2_r, pat_phase_r);
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      word_cfg_r <= '0;
      word_r <= '0;
      pat_phase_r <= 1'b0;
    end else if (boundary) begin
      word_cfg_r <= live_cfg;
      word_r <= running ? word_nxt : '0;
      pat_phase_r <= ~pat_phase_r;
    end
  end

  // clock delay as eighths of the measured period; 135 deg plus half stays inside the period
  wire [7:0] half = {1'b0, period_r[7:1]};
  wire [9:0] del_prod = {2'b00, period_r} * {8'h00, word_cfg_r.clock_delay_field};
  wire [7:0] del = {1'b0, del_prod[9:3]};
  wire [8:0] low_end = {1'b0, half} + {1'b0, del};
  // live delay feeds the clock for the sample being launched
  wire [9:0] del_prod_l = {2'b00, period_r} * {8'h00, live_cfg.clock_delay_field};
  wire [7:0] use_del = boundary ? {1'b0, del_prod_l[9:3]} : del;
  wire [8:0] use_end = boundary ? ({1'b0, half} + {1'b0, use_del}) : low_end;
  wire use_inv = boundary ? live_cfg.clock_invert : word_cfg_r.clock_invert;
  // true clock is low for the first half after a boundary so data moves on its falling edge
  wire clk_low = (cyc_nxt >= use_del) && ({1'b0, cyc_nxt} < use_end);
  wire clk_nxt = running & ((~clk_low) ^ use_inv);

  // ddr second half launches at the undelayed rising edge
  wire mid = !boundary && (cyc_nxt == half) && (half != 8'h00);
  wire ddr_now = boundary ? is_ddr(live_cfg.output_mode_field) : is_ddr(word_cfg_r.output_mode_field);
  wire aof_pkg::aof_word_t launch = boundary ? (running ? word_nxt : aof_pkg::aof_word_t'('0)) : word_r;
  wire second = mid;
  logic [13:0] ddr_lines;
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++) begin : g_ddr
      // even bit leads, odd bit follows on the same line
      assign ddr_lines[gi] = second ? launch.bits[2 * gi + 1] : launch.bits[2 * gi];
      assign ddr_lines[gi + 7] = 1'b0;
    end
  endgenerate

  // output registers; hi-z clears every enable including flag and clock
  wire hiz = boundary ? live_cfg.output_hiz : word_cfg_r.output_hiz;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sample_bits <= 14'h0000;
      overrange_flag <= 1'b0;
      forwarded_sample_clock <= 1'b0;
      sample_bits_oe <= 14'h0000;
      overrange_flag_oe <= 1'b0;
      forwarded_sample_clock_oe <= 1'b0;
    end else begin
      if (boundary || (mid && ddr_now)) begin
        sample_bits <= ddr_now ? ddr_lines : launch.bits;
        overrange_flag <= launch.ovr;
      end
      forwarded_sample_clock <= clk_nxt;
      sample_bits_oe <= hiz ? 14'h0000 : (ddr_now ? 14'h007F : 14'h3FFF);
      overrange_flag_oe <= ~hiz;
      forwarded_sample_clock_oe <= ~hiz;
    end
  end

  // driver and analog control levels; the clock invert and delay need the stabilizer (far side duty), but neither is gated by it here
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lvds_select <= 1'b0;
      lvds_current <= 3'h0;
      lvds_term_en <= 1'b0;
      duty_cycle_stabilizer <= 1'b0;
      core_nap <= 1'b0;
      core_sleep <= 1'b0;
      output_ready <= 1'b1;
    end else begin
      lvds_select <= word_cfg_r.output_mode_field == aof_pkg::MODE_DDR_LVDS;
      lvds_current <= live_cfg.lvds_current;
      lvds_term_en <= live_cfg.term_en;
      duty_cycle_stabilizer <= live_cfg.duty_cycle_stabilizer;
      core_nap <= want_nap;
      core_sleep <= want_sleep;
      output_ready <= pwr_nxt == aof_pkg::AOF_RUN;
    end
  end

  // read mux, data one cycle after the strobe; reset register reads zero
  logic [7:0] rd_mux;
  always_comb begin
    case (reg_addr)
      aof_pkg::ADDR_POWER: rd_mux = {6'h00, cfg_r.power_state_field};
      aof_pkg::ADDR_TIMING: rd_mux = {4'h0, cfg_r.clock_invert, cfg_r.clock_delay_field, cfg_r.duty_cycle_stabilizer};
      aof_pkg::ADDR_OUTPUT_MODE_FIELD: rd_mux = {1'b0, cfg_r.lvds_current, cfg_r.term_en, cfg_r.output_hiz,
                                       cfg_r.output_mode_field};
      aof_pkg::ADDR_FORMAT: rd_mux = {2'h0, cfg_r.pattern_select, cfg_r.alternate_polarity_mode,
                                      cfg_r.output_scrambler_enable, cfg_r.signed_format_select};
      aof_pkg::ADDR_STATUS: rd_mux = {5'h00, ~running, par_mode, output_ready};
      default: rd_mux = 8'h00;
    endcase
  end
  always_ff @(posedge ref_clk) begin
    if (rst)
      reg_rdata <= 8'h00;
    else
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
  end

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_flag_with_data: assert property (boundary && running && live_cfg.pattern_select == 3'h0 &&
      !smp_s2_r[15] && smp_s2_r > 16'h1FFF |=> overrange_flag && word_r.ovr && word_r.bits[0])
    else $error("overrange flag not raised with clamped code");
  a_zero_pattern: assert property (boundary && running && live_cfg.pattern_select == 3'h1 |=>
      word_r == 15'h0000)
    else $error("zero pattern not emitted");
  a_ones_override: assert property (boundary && running && live_cfg.pattern_select == 3'h3 |=>
      word_r == 15'h7FFF)
    else $error("ones pattern overridden by formatting");
  a_abp_forces_ob: assert property (boundary && running && live_cfg.pattern_select == 3'h0 &&
      live_cfg.alternate_polarity_mode && !live_cfg.output_scrambler_enable &&
      smp_s2_r == 16'h0005 |=> word_r.bits == 14'h0AAF)
    else $error("midscale with alternate polarity wrong");
  a_signed_mid: assert property (boundary && running && live_cfg.pattern_select == 3'h0 &&
      live_cfg.signed_format_select && !live_cfg.alternate_polarity_mode &&
      !live_cfg.output_scrambler_enable && smp_s2_r == 16'h0000 |=> word_r.bits == 14'h0000)
    else $error("signed midscale wrong");
  a_hiz_all: assert property (live_cfg.output_hiz && boundary |=> !overrange_flag_oe &&
      !forwarded_sample_clock_oe && sample_bits_oe == 14'h0000)
    else $error("outputs still driven in disable");
  a_par_no_nap: assert property (par_mode |-> !want_nap)
    else $error("nap reached from straps");
  a_sleep_wait: assert property (pwr_r == aof_pkg::AOF_WAKE && from_sleep_r && wake_cnt_r < 16'(SLEEP_WAKE - 1) |->
      pwr_nxt != aof_pkg::AOF_RUN)
    else $error("sleep wake too early");
  a_nap_samples: assert property (pwr_r == aof_pkg::AOF_WAKE && !from_sleep_r && !smp_done |=>
      !output_ready)
    else $error("nap wake before sample count");
  a_word_frozen: assert property (!boundary |=> $stable(word_cfg_r))
    else $error("settings changed inside a sample");
endmodule

// ===== tb/aof_rx_model.sv
// receiving logic model: latches words on the forwarded clock and undoes scrambling and polarity
`timescale 1ns/1ps
module aof_rx_model (
  // link side
  input wire logic forwarded_sample_clock,
  input wire logic [13:0] sample_bits,
  input wire logic overrange_flag,
  // decode settings and recovered word
  input wire logic unscramble,
  input wire logic unflip,
  output logic [14:0] rx_word
);
  logic [13:0] flip;
  // capture on the rising edge, data has been steady since the falling edge
  always @(posedge forwarded_sample_clock) begin
    flip = unflip ? sample_bits ^ 14'h2AAA : sample_bits;
    rx_word <= {overrange_flag, unscramble ? {flip[13:1] ^ {13{flip[0]}}, flip[0]} : flip};
  end
endmodule

// ===== tb/tb.sv
// self-checking bench for the sample output formatter
`timescale 1ns/1ps
module tb;
  logic ref_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, enc_clk_pin = 1'b0;
  logic [6:0] reg_addr = 7'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [15:0] core_sample_pin = 16'h0000;
  logic mode_strap = 1'b0, sel_strap = 1'b0, clk_strap = 1'b0, in_strap = 1'b0;
  logic [2:0] lvds_current;
  logic lvds_term_en, duty_cycle_stabilizer;
  logic [7:0] reg_rdata;
  logic [13:0] sample_bits, sample_bits_oe;
  logic overrange_flag, overrange_flag_oe, forwarded_sample_clock, forwarded_sample_clock_oe;
  logic lvds_select, core_nap, core_sleep, output_ready;
  logic [14:0] rx_word;
  wire [14:0] dout_word = {overrange_flag, sample_bits};
  int err_total = 0;
  int checked = 0;
  // 25 MHz system clock; encode clock runs at 320 ns, one sample every 8 cycles
  always #20 ref_clk = ~ref_clk;
  always #160 enc_clk_pin = ~enc_clk_pin;
  // short wake count keeps the sleep recovery run brief
  aof_formatter #(.SLEEP_WAKE(20)) u_dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .enc_clk_pin(enc_clk_pin), .core_sample_pin(core_sample_pin), .programming_mode_select(mode_strap),
    .select_strap_pin(sel_strap), .clock_strap_pin(clk_strap), .input_strap_pin(in_strap),
    .sample_bits(sample_bits), .sample_bits_oe(sample_bits_oe), .overrange_flag(overrange_flag),
    .overrange_flag_oe(overrange_flag_oe), .forwarded_sample_clock(forwarded_sample_clock),
    .forwarded_sample_clock_oe(forwarded_sample_clock_oe), .lvds_select(lvds_select), .lvds_current(lvds_current),
    .lvds_term_en(lvds_term_en), .duty_cycle_stabilizer(duty_cycle_stabilizer), .core_nap(core_nap),
    .core_sleep(core_sleep), .output_ready(output_ready));
  // receiver decodes both scrambling and polarity, so only its doubly coded case is compared
  aof_rx_model u_rx (.forwarded_sample_clock(forwarded_sample_clock), .sample_bits(sample_bits),
    .overrange_flag(overrange_flag), .unscramble(1'b1), .unflip(1'b1), .rx_word(rx_word));
  task automatic wrap_up;
    if (err_total == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // read data is looked at only in the cycle after the strobe
  task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    chk(16'(reg_rdata), 16'(exp));
  endtask
  // settings land at a sample boundary, so wait five samples before looking
  task automatic go(input logic [6:0] a, input logic [7:0] d, input logic [15:0] s);
    wr(a, d);
    core_sample_pin <= s;
    repeat (40) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  task automatic t_regs;
    wr(aof_pkg::ADDR_TIMING, 8'h0F);
    rd_chk(aof_pkg::ADDR_TIMING, 8'h0F);
    rd_chk(7'h7F, 8'h00);
    wr(aof_pkg::ADDR_RESET, 8'h80);
    rd_chk(aof_pkg::ADDR_TIMING, 8'h00);
    rd_chk(aof_pkg::ADDR_RESET, 8'h00);
  endtask
  task automatic t_format;
    go(aof_pkg::ADDR_FORMAT, 8'h00, 16'h0000); chk(16'(dout_word), 16'h2000);
    go(aof_pkg::ADDR_FORMAT, 8'h01, 16'h0000); chk(16'(dout_word), 16'h0000);
    go(aof_pkg::ADDR_FORMAT, 8'h01, 16'h1FFF); chk(16'(dout_word), 16'h1FFF);
    go(aof_pkg::ADDR_FORMAT, 8'h00, 16'd9000); chk(16'(dout_word), 16'h7FFF);
    go(aof_pkg::ADDR_FORMAT, 8'h01, 16'd9000); chk(16'(dout_word), 16'h5FFF);
    go(aof_pkg::ADDR_FORMAT, 8'h00, 16'hDCD8); chk(16'(dout_word), 16'h4000);
    go(aof_pkg::ADDR_FORMAT, 8'h02, 16'h0005); chk(16'(dout_word), 16'h1FFB);
    go(aof_pkg::ADDR_FORMAT, 8'h04, 16'h0005); chk(16'(dout_word), 16'h0AAF);
    go(aof_pkg::ADDR_FORMAT, 8'h05, 16'h0005); chk(16'(dout_word), 16'h0AAF);
    go(aof_pkg::ADDR_FORMAT, 8'h06, 16'h0005); chk(16'(dout_word), 16'h3551);
    chk(16'(rx_word), 16'h2005);
    go(aof_pkg::ADDR_FORMAT, 8'h1B, 16'h0005); chk(16'(dout_word), 16'h7FFF);
    go(aof_pkg::ADDR_FORMAT, 8'h0F, 16'h0005); chk(16'(dout_word), 16'h0000);
  endtask
  // checkerboard and alternating both flip every output on successive samples
  task automatic t_patterns;
    logic [14:0] first;
    for (int i = 0; i < 2; i++) begin
      go(aof_pkg::ADDR_FORMAT, i ? 8'h38 : 8'h28, 16'h0000);
      first = dout_word;
      repeat (8) @(posedge ref_clk);
      @(negedge ref_clk);
      chk(16'(first ^ dout_word), 16'h7FFF);
      chk(16'(first == (i ? 15'h7FFF : 15'h5555) || first == (i ? 15'h0000 : 15'h2AAA)), 16'h0001);
    end
  endtask
  task automatic t_out;
    go(aof_pkg::ADDR_OUTPUT_MODE_FIELD, 8'h04, 16'h0000);
    chk(16'({sample_bits_oe, overrange_flag_oe, forwarded_sample_clock_oe}), 16'h0000);
    go(aof_pkg::ADDR_OUTPUT_MODE_FIELD, 8'h59, 16'h0000);
    chk(16'({lvds_select, sample_bits_oe}), 16'h407F);
    chk(16'({lvds_current, lvds_term_en}), 16'h000B);
    go(aof_pkg::ADDR_OUTPUT_MODE_FIELD, 8'h00, 16'h0000);
    chk(16'({lvds_select, sample_bits_oe}), 16'h3FFF);
  endtask
  // even bits ride while the true clock is low, odd bits while it is high; delay and invert move the clock only
  task automatic t_ddr;
    int hits;
    int lows;
    go(aof_pkg::ADDR_FORMAT, 8'h00, 16'hF555);
    go(aof_pkg::ADDR_OUTPUT_MODE_FIELD, 8'h59, 16'hF555);
    for (int k = 0; k < 3; k++) begin
      go(aof_pkg::ADDR_TIMING, k == 0 ? 8'h00 : (k == 1 ? 8'h08 : 8'h05), 16'hF555);
      hits = 0;
      lows = 0;
      repeat (8) begin
        @(negedge ref_clk);
        hits += int'(forwarded_sample_clock == (sample_bits == 14'h0000));
        lows += int'(sample_bits == 14'h007F);
      end
      chk(16'(hits), k == 0 ? 16'h0008 : (k == 1 ? 16'h0000 : 16'h0004));
      chk(16'(lows), 16'h0004);
    end
  endtask
  // strap mode ignores the registers, so a nap written over the port stays without effect
  task automatic t_par;
    @(posedge ref_clk);
    {mode_strap, sel_strap, clk_strap} <= 3'h5;
    go(aof_pkg::ADDR_POWER, 8'h01, 16'h0000);
    chk(16'({lvds_select, sample_bits_oe}), 16'h407F);
    chk(16'({lvds_current, lvds_term_en}), 16'h0000);
    chk(16'({duty_cycle_stabilizer, core_nap, core_sleep}), 16'h0000);
    @(posedge ref_clk);
    {sel_strap, in_strap} <= 2'h3;
    go(aof_pkg::ADDR_POWER, 8'h00, 16'h0000);
    chk(16'({duty_cycle_stabilizer, core_sleep, output_ready}), 16'h0006);
    rd_chk(aof_pkg::ADDR_STATUS, 8'h06);
    @(posedge ref_clk);
    {mode_strap, sel_strap, clk_strap, in_strap} <= 4'h0;
    go(aof_pkg::ADDR_OUTPUT_MODE_FIELD, 8'h00, 16'h0000);
  endtask
  // sleep wakes after the short count, nap needs 100 samples plus the settle time
  task automatic t_pwr;
    go(aof_pkg::ADDR_POWER, 8'h03, 16'h0000);
    chk(16'({core_sleep, core_nap, output_ready}), 16'h0004);
    rd_chk(aof_pkg::ADDR_STATUS, 8'h04);
    wr(aof_pkg::ADDR_POWER, 8'h00);
    repeat (19) @(posedge ref_clk);
    @(negedge ref_clk);
    chk(16'(output_ready), 16'h0000);
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    chk(16'(output_ready), 16'h0001);
    go(aof_pkg::ADDR_POWER, 8'h01, 16'h0000);
    chk(16'({core_sleep, core_nap, output_ready}), 16'h0002);
    go(aof_pkg::ADDR_POWER, 8'h00, 16'h0000);
    chk(16'(output_ready), 16'h0000);
    repeat (1900) @(posedge ref_clk);
    @(negedge ref_clk);
    chk(16'(output_ready), 16'h0000);
    repeat (300) @(posedge ref_clk);
    @(negedge ref_clk);
    chk(16'(output_ready), 16'h0001);
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs;
    t_format;
    t_patterns;
    t_out;
    t_ddr;
    t_par;
    t_pwr;
    wrap_up;
  end
  // the whole run needs well under 200 us
  initial begin
    #400_000;
    err_total++;
    wrap_up;
  end
endmodule
